//--- inc/btrc_pkg.sv
// package: constants and carriers for branch trace record control
`default_nettype none
package btrc_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_DEBUG_CTRL = 12'h000;
  localparam logic [11:0] OFF_GLOBAL_EN = 12'h004;
  localparam logic [11:0] OFF_CAPABILITY = 12'h008;
  localparam logic [11:0] OFF_ID_ECX = 12'h00c;
  localparam logic [11:0] OFF_NEWEST_PTR = 12'h010;
  localparam logic [11:0] OFF_LOG_BASE = 12'h014;
  localparam logic [11:0] OFF_LOG_INDEX = 12'h018;
  localparam logic [11:0] OFF_LOG_MAX = 12'h01c;
  localparam logic [11:0] OFF_LOG_THRESH = 12'h020;
  localparam logic [11:0] OFF_STATUS = 12'h024;
  localparam logic [3:0] PAGE_SRC_SLOTS = 4'h1;
  localparam logic [3:0] PAGE_TGT_SLOTS = 4'h2;
  // debug control fields
  localparam int unsigned BIT_REC_EN = 0;
  localparam int unsigned BIT_MSG_EN = 6;
  localparam int unsigned BIT_LOG_EN = 7;
  localparam int unsigned BIT_LOG_INT = 8;
  localparam int unsigned BIT_SKIP_KERN = 9;
  localparam int unsigned BIT_SKIP_USER = 10;
  localparam int unsigned BIT_FRZ_REC = 11;
  localparam int unsigned BIT_FRZ_CNT = 12;
  localparam logic [31:0] DEBUG_CTRL_MASK = 32'h00001fc1;
  // status fields
  localparam int unsigned BIT_ST_THRESH = 0;
  localparam int unsigned BIT_ST_FULL = 1;
  // reset values
  localparam logic [31:0] DEBUG_CTRL_RST = 32'h00000000;
  localparam logic [31:0] LOG_REG_RST = 32'h00000000;
  localparam logic CNT_EN_RST = 1'b0;
  // identification and capability
  localparam int unsigned ID_BIT_PRIV_SKIP = 4;
  localparam int unsigned ID_BIT_CAPAB = 15;
  localparam int unsigned CAP_FMT_W = 6;
  localparam logic [5:0] FMT_SEG32 = 6'h00;
  localparam logic [5:0] FMT_LIN64 = 6'h01;
  localparam logic [5:0] FMT_EFF64 = 6'h02;
  localparam logic [5:0] FMT_EFF64_FLAGS = 6'h03;
  // overflow interrupt enables
  localparam int unsigned EVTSEL_INT_BIT = 20;
  localparam int unsigned FIXED_FIELD_W = 4;
  localparam int unsigned FIXED_INT_BIT = 3;
  // memory log record sizes in bytes
  localparam logic [31:0] REC_BYTES_32 = 32'h0000000c;
  localparam logic [31:0] REC_BYTES_64 = 32'h00000018;

  typedef enum logic [1:0] {
    BTRC_KIND_BRANCH = 2'h1,
    BTRC_KIND_INTR = 2'h2,
    BTRC_KIND_EXCEPT = 2'h3
  } btrc_kind_e;

  typedef struct packed {
    logic [63:0] src;
    logic [63:0] tgt;
    btrc_kind_e kind;
  } btrc_rec_s;
endpackage
`default_nettype wire

//--- verilog/btrc_top.sv
// branch trace record control: record stack, bus messages, memory log
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE_01: record enable captures every branch into stack
// RULE_02: message enable sends each record on bus
// RULE_03: log enable writes each record to memory
// RULE_04: log buffer wraps or interrupts near full
// RULE_05: log interrupt enable stops wrap, raises interrupt
// RULE_06: identification bit 4 reports privilege skip support
// RULE_07: bits 10 and 9 skip user/kernel traces
// RULE_08: kernel skip at level 0, user above
// RULE_09: perf interrupt clears record enable when frozen
// RULE_10: software re-enables recording after a freeze
// RULE_11: perf interrupt clears global counter enables
// RULE_12: software restarts counters before leaving handler
// RULE_13: enabled counter overflow triggers the freeze
// RULE_14: sampling or log threshold also triggers freeze
// RULE_15: stack depth is 16, 8 or 4
// RULE_16: branches, interrupts, traps and faults all recorded
// RULE_17: source and target slots in parallel runs
// RULE_18: newest pointer low bits index newest slot
// RULE_19: pointer advances modulo depth, oldest overwritten
// RULE_20: 64-bit slots, low 32 outside extended mode
// RULE_21: compatibility mode clears upper 32 bits
// RULE_22: capability bits 5:0 report record format
// RULE_23: identification bit 15 reports capability register
// RULE_24: legacy mode packs target and source halves
// RULE_25: debug exception clears record enable, keeps stack
module btrc_top #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned NUM_GP = 4,
  parameter int unsigned NUM_FX = 3,
  parameter logic [5:0] REC_FORMAT = btrc_pkg::FMT_EFF64,
  parameter bit PRIV_SKIP_SUPPORT = 1'b1,
  parameter bit LEGACY_PACK = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic br_valid_i,
  input wire btrc_pkg::btrc_rec_s br_rec_i,
  output logic br_ready_o,
  input wire logic [1:0] cpl_i,
  input wire logic ext_mode_i,
  input wire logic mode64_i,
  input wire logic debug_exc_i,
  input wire logic [NUM_GP-1:0] gp_ovf_i,
  input wire logic [NUM_GP-1:0][31:0] gp_evtsel_i,
  input wire logic [NUM_FX-1:0] fx_ovf_i,
  input wire logic [NUM_FX*btrc_pkg::FIXED_FIELD_W-1:0] fx_ctrl_i,
  input wire logic sample_thresh_i,
  output logic [NUM_GP+NUM_FX-1:0] counter_enable_o,
  output logic pmi_o,
  output logic bus_msg_valid_o,
  output btrc_pkg::btrc_rec_s bus_msg_o,
  input wire logic bus_msg_ready_i,
  output logic log_valid_o,
  output logic [31:0] log_addr_o,
  output btrc_pkg::btrc_rec_s log_rec_o,
  input wire logic log_ready_i
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned NCNT = NUM_GP + NUM_FX;

  if (!(DEPTH == 4 || DEPTH == 8 || DEPTH == 16)) begin : g_bad_depth
    $error("stack depth must be 4, 8 or 16"); // [RULE_15]
  end
  if (NUM_GP < 1 || NUM_FX < 1 || NCNT > 32) begin : g_bad_cnt
    $error("counter counts out of range");
  end
  if (REC_FORMAT > btrc_pkg::FMT_EFF64_FLAGS) begin : g_bad_fmt
    $error("record format code undefined");
  end

  typedef struct packed {
    logic [31:0] dbg;
    logic [NCNT-1:0] cnt_en;
    logic [31:0] log_base;
    logic [31:0] log_index;
    logic [31:0] log_max;
    logic [31:0] log_thresh;
    logic log_hit;
    logic log_full;
    logic [PTR_W-1:0] ptr;
    logic [DEPTH-1:0][63:0] src;
    logic [DEPTH-1:0][63:0] tgt;
    logic msg_valid;
    btrc_pkg::btrc_rec_s msg_rec;
    logic log_valid;
    logic [31:0] log_addr;
    btrc_pkg::btrc_rec_s log_rec;
    logic perf_monitor_interrupt;
    logic [31:0] rdata;
    logic slverr;
  } btrc_state_s;

  btrc_state_s q;
  btrc_state_s d;

  logic setup;
  logic wr;
  logic [11:0] word_addr;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [PTR_W-1:0] slot_idx;
  logic slot_in_range;
  logic skip;
  logic wide;
  logic capture;
  logic send;
  logic logit;
  logic take;
  logic [63:0] rec_src;
  logic [63:0] rec_tgt;
  logic [63:0] slot_src;
  logic [63:0] slot_tgt;
  logic [31:0] rec_bytes;
  logic [31:0] log_nxt;
  logic [32:0] room_end;
  logic no_room;
  logic thr_hit;
  logic log_pmi;
  logic [NUM_GP-1:0] gp_int;
  logic [NUM_FX-1:0] fx_int;
  logic pmi_req;

  // APB slave, zero wait states
  assign setup = psel_i && !penable_i;
  assign word_addr = {paddr_i[11:2], 2'b00};
  assign slot_idx = paddr_i[3+PTR_W-1:3];
  assign slot_in_range = 32'(paddr_i[7:3]) < DEPTH;
  assign wr = psel_i && penable_i && pwrite_i && !q.slverr;

  always_comb begin
    rd_val = 32'h0;
    rd_ok = (paddr_i[1:0] == 2'b00);
    case (word_addr)
      btrc_pkg::OFF_DEBUG_CTRL: rd_val = q.dbg;
      btrc_pkg::OFF_GLOBAL_EN: rd_val[NCNT-1:0] = q.cnt_en;
      btrc_pkg::OFF_CAPABILITY: begin
        rd_val[btrc_pkg::CAP_FMT_W-1:0] = REC_FORMAT; // [RULE_22]
      end
      btrc_pkg::OFF_ID_ECX: begin
        rd_val[btrc_pkg::ID_BIT_PRIV_SKIP] = PRIV_SKIP_SUPPORT; // [RULE_06]
        rd_val[btrc_pkg::ID_BIT_CAPAB] = 1'b1; // [RULE_23]
      end
      btrc_pkg::OFF_NEWEST_PTR: rd_val[PTR_W-1:0] = q.ptr; // [RULE_18]
      btrc_pkg::OFF_LOG_BASE: rd_val = q.log_base;
      btrc_pkg::OFF_LOG_INDEX: rd_val = q.log_index;
      btrc_pkg::OFF_LOG_MAX: rd_val = q.log_max;
      btrc_pkg::OFF_LOG_THRESH: rd_val = q.log_thresh;
      btrc_pkg::OFF_STATUS: begin
        rd_val[btrc_pkg::BIT_ST_THRESH] = q.log_hit;
        rd_val[btrc_pkg::BIT_ST_FULL] = q.log_full;
      end
      default: begin
        // source run on one page, target run on the next
        if (paddr_i[11:8] == btrc_pkg::PAGE_SRC_SLOTS && slot_in_range) begin
          rd_val = paddr_i[2] ? q.src[slot_idx][63:32] :
                                q.src[slot_idx][31:0]; // [RULE_17]
        end else if (paddr_i[11:8] == btrc_pkg::PAGE_TGT_SLOTS &&
                     slot_in_range) begin
          rd_val = paddr_i[2] ? q.tgt[slot_idx][63:32] :
                                q.tgt[slot_idx][31:0]; // [RULE_17]
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // branch record path
  assign skip = (q.dbg[btrc_pkg::BIT_SKIP_KERN] && cpl_i == 2'd0) ||
                (q.dbg[btrc_pkg::BIT_SKIP_USER] && cpl_i != 2'd0); // [RULE_07] [RULE_08]
  // compatibility sub-mode keeps only the low half
  assign wide = ext_mode_i && mode64_i; // [RULE_20] [RULE_21]
  assign rec_src = wide ? br_rec_i.src : {32'h0, br_rec_i.src[31:0]};
  assign rec_tgt = wide ? br_rec_i.tgt : {32'h0, br_rec_i.tgt[31:0]};
  assign slot_src = LEGACY_PACK ?
                    {br_rec_i.tgt[31:0], br_rec_i.src[31:0]} : rec_src; // [RULE_24]
  assign slot_tgt = LEGACY_PACK ? 64'h0 : rec_tgt;
  // message enable also keeps the stack updating; messages take the incoming record, not the stack
  assign capture = q.dbg[btrc_pkg::BIT_REC_EN] ||
                   q.dbg[btrc_pkg::BIT_MSG_EN]; // [RULE_01] [RULE_16]
  assign send = q.dbg[btrc_pkg::BIT_MSG_EN] && !skip; // [RULE_02]
  assign logit = q.dbg[btrc_pkg::BIT_LOG_EN] && !skip && !q.log_full; // [RULE_03]
  // no queue: a pending message or log write stalls the next record
  assign br_ready_o = !q.msg_valid && !q.log_valid;
  assign take = br_valid_i && br_ready_o;

  assign rec_bytes = wide ? btrc_pkg::REC_BYTES_64 : btrc_pkg::REC_BYTES_32;
  assign log_nxt = q.log_index + rec_bytes;
  assign room_end = {1'b0, log_nxt} + {1'b0, rec_bytes};
  assign no_room = room_end > {1'b0, q.log_max};
  assign thr_hit = q.log_index <= q.log_thresh && log_nxt > q.log_thresh;
  assign log_pmi = take && logit && thr_hit &&
                   q.dbg[btrc_pkg::BIT_LOG_INT]; // [RULE_05]

  // freeze triggers
  for (genvar g = 0; g < NCNT; g++) begin : g_trig
    if (g < NUM_GP) begin : g_gp
      assign gp_int[g] = gp_ovf_i[g] &&
                         gp_evtsel_i[g][btrc_pkg::EVTSEL_INT_BIT]; // [RULE_13]
    end else begin : g_fx
      assign fx_int[g-NUM_GP] = fx_ovf_i[g-NUM_GP] &&
        fx_ctrl_i[(g-NUM_GP)*btrc_pkg::FIXED_FIELD_W +
                  btrc_pkg::FIXED_INT_BIT]; // [RULE_13]
    end
  end
  assign pmi_req = (|gp_int) || (|fx_int) || sample_thresh_i ||
                   log_pmi; // [RULE_14]

  // next state
  always_comb begin
    d = q;
    d.perf_monitor_interrupt = pmi_req;
    if (setup) begin
      d.rdata = rd_val;
      d.slverr = !rd_ok;
    end
    if (wr) begin
      case (word_addr)
        btrc_pkg::OFF_DEBUG_CTRL: d.dbg = pwdata_i & btrc_pkg::DEBUG_CTRL_MASK;
        btrc_pkg::OFF_GLOBAL_EN: d.cnt_en = pwdata_i[NCNT-1:0];
        btrc_pkg::OFF_LOG_BASE: d.log_base = pwdata_i;
        btrc_pkg::OFF_LOG_INDEX: begin
          d.log_index = pwdata_i;
          d.log_full = 1'b0;
        end
        btrc_pkg::OFF_LOG_MAX: d.log_max = pwdata_i;
        btrc_pkg::OFF_LOG_THRESH: d.log_thresh = pwdata_i;
        btrc_pkg::OFF_STATUS: begin
          if (pwdata_i[btrc_pkg::BIT_ST_THRESH]) begin
            d.log_hit = 1'b0;
          end
          if (pwdata_i[btrc_pkg::BIT_ST_FULL]) begin
            d.log_full = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (q.msg_valid && bus_msg_ready_i) begin
      d.msg_valid = 1'b0;
    end
    if (q.log_valid && log_ready_i) begin
      d.log_valid = 1'b0;
    end
    if (take && capture) begin
      d.ptr = q.ptr + PTR_W'(1); // [RULE_19]
      d.src[d.ptr] = slot_src;
      d.tgt[d.ptr] = slot_tgt;
    end
    if (take && send) begin
      d.msg_valid = 1'b1; // [RULE_02]
      d.msg_rec = '{src: rec_src, tgt: rec_tgt, kind: br_rec_i.kind};
    end
    if (take && logit) begin
      d.log_valid = 1'b1; // [RULE_03]
      d.log_addr = q.log_index;
      d.log_rec = '{src: rec_src, tgt: rec_tgt, kind: br_rec_i.kind};
      if (q.dbg[btrc_pkg::BIT_LOG_INT]) begin
        // never overwrite: stop logging at the end of the buffer
        d.log_index = log_nxt; // [RULE_05]
        if (no_room) begin
          d.log_full = 1'b1;
        end
      end else begin
        d.log_index = no_room ? q.log_base : log_nxt; // [RULE_04]
      end
      if (thr_hit) begin
        d.log_hit = 1'b1;
      end
    end
    // hardware clears win over a software write in the same cycle
    if (pmi_req && q.dbg[btrc_pkg::BIT_FRZ_REC]) begin
      d.dbg[btrc_pkg::BIT_REC_EN] = 1'b0; // [RULE_09]
    end
    if (pmi_req && q.dbg[btrc_pkg::BIT_FRZ_CNT]) begin
      d.cnt_en = '0; // [RULE_11]
    end
    if (debug_exc_i) begin
      d.dbg[btrc_pkg::BIT_REC_EN] = 1'b0; // [RULE_25]
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.dbg <= btrc_pkg::DEBUG_CTRL_RST;
      q.cnt_en <= {NCNT{btrc_pkg::CNT_EN_RST}};
      q.log_base <= btrc_pkg::LOG_REG_RST;
      q.log_index <= btrc_pkg::LOG_REG_RST;
      q.log_max <= btrc_pkg::LOG_REG_RST;
      q.log_thresh <= btrc_pkg::LOG_REG_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && q.slverr;
  assign counter_enable_o = q.cnt_en;
  assign pmi_o = q.perf_monitor_interrupt;
  assign bus_msg_valid_o = q.msg_valid;
  assign bus_msg_o = q.msg_rec;
  assign log_valid_o = q.log_valid;
  assign log_addr_o = q.log_addr;
  assign log_rec_o = q.log_rec;

  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_ptr_advance: assert property ( // [RULE_19]
    take && capture |=> q.ptr == $past(q.ptr) + PTR_W'(1))
    else $error("newest pointer did not advance");

  a_freeze_rec: assert property ( // [RULE_09]
    pmi_req && q.dbg[btrc_pkg::BIT_FRZ_REC]
    |=> !q.dbg[btrc_pkg::BIT_REC_EN] && pmi_o)
    else $error("record enable not frozen");

  a_freeze_cnt: assert property ( // [RULE_11]
    pmi_req && q.dbg[btrc_pkg::BIT_FRZ_CNT] |=> counter_enable_o == '0)
    else $error("counters not frozen");

  a_overflow_pmi: assert property ( // [RULE_13]
    (|(gp_ovf_i & gp_int)) |=> pmi_o)
    else $error("counter overflow gave no interrupt");

  a_dbg_keep: assert property ( // [RULE_25]
    debug_exc_i && !take
    |=> !q.dbg[btrc_pkg::BIT_REC_EN] && q.ptr == $past(q.ptr))
    else $error("debug exception left recording on");

  a_msg_sent: assert property ( // [RULE_02]
    take && send |=> bus_msg_valid_o && bus_msg_o.src == $past(rec_src))
    else $error("bus message missing");

  a_msg_hold: assert property ( // [RULE_02]
    bus_msg_valid_o && !bus_msg_ready_i
    |=> bus_msg_valid_o && $stable(bus_msg_o))
    else $error("bus message dropped before acceptance");

  a_skip_drop: assert property ( // [RULE_08]
    take && skip |=> !bus_msg_valid_o && !log_valid_o)
    else $error("skipped privilege level still traced");

  a_upper_clear: assert property ( // [RULE_21]
    take && capture && !wide && !LEGACY_PACK
    |=> q.src[q.ptr][63:32] == 32'h0 && q.tgt[q.ptr][63:32] == 32'h0)
    else $error("upper half not cleared");

  a_log_wrap: assert property ( // [RULE_04]
    take && logit && no_room && !q.dbg[btrc_pkg::BIT_LOG_INT]
    |=> q.log_index == $past(q.log_base) && log_valid_o)
    else $error("log did not wrap to base");

  a_log_thresh: assert property ( // [RULE_05]
    log_pmi |=> pmi_o ##0 q.log_hit)
    else $error("log threshold gave no interrupt");
endmodule
`default_nettype wire

//--- test/btrc_partner.sv
// partner: trace bus monitor and memory log sink with random stalls
`timescale 1ns/1ps
`default_nettype none
module btrc_partner (
  input wire logic clock_i,
  input wire logic msg_valid_i,
  input wire btrc_pkg::btrc_rec_s msg_i,
  output logic msg_ready_o,
  input wire logic log_valid_i,
  input wire logic [31:0] log_addr_i,
  input wire btrc_pkg::btrc_rec_s log_i,
  output logic log_ready_o,
  output int n_msg_o,
  output int n_log_o,
  output btrc_pkg::btrc_rec_s last_msg_o,
  output btrc_pkg::btrc_rec_s last_log_o,
  output logic [31:0] last_addr_o
);
  initial begin
    msg_ready_o = 1'b0;
    log_ready_o = 1'b0;
    n_msg_o = 0;
    n_log_o = 0;
  end
  // random stalls force the block to hold its offers
  always @(posedge clock_i) begin
    msg_ready_o <= 1'($urandom_range(0, 1));
    log_ready_o <= 1'($urandom_range(0, 1));
    if (msg_valid_i && msg_ready_o) begin
      n_msg_o <= n_msg_o + 1;
      last_msg_o <= msg_i;
    end
    if (log_valid_i && log_ready_o) begin
      n_log_o <= n_log_o + 1;
      last_log_o <= log_i;
      last_addr_o <= log_addr_i;
    end
  end
endmodule
`default_nettype wire

//--- test/btrc_tb_top.sv
// testbench: random and corner-case checks of branch trace record control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module btrc_tb_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, laddr, ea;
  logic br_valid, br_ready, ext, m64, dexc, sthr, perf_monitor_interrupt, mv, lv, mr, lr;
  btrc_pkg::btrc_rec_s br_rec, msg, lrec, lmsg, llog, sent;
  logic [1:0] current_privilege_level, x;
  logic [3:0] gov;
  logic [3:0][31:0] gsel;
  logic [2:0] fov;
  logic [11:0] fctl;
  logic [6:0] cen;
  logic [63:0] e;
  int n_msg, n_log, n_pmi, n_errors, checks_done, ep, k, c, m0, inc;

  btrc_top #(.DEPTH(4)) dut (.clock_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .br_valid_i(br_valid),
    .br_rec_i(br_rec), .br_ready_o(br_ready), .cpl_i(current_privilege_level),
    .ext_mode_i(ext), .mode64_i(m64), .debug_exc_i(dexc),
    .gp_ovf_i(gov), .gp_evtsel_i(gsel), .fx_ovf_i(fov),
    .fx_ctrl_i(fctl), .sample_thresh_i(sthr), .counter_enable_o(cen),
    .pmi_o(perf_monitor_interrupt), .bus_msg_valid_o(mv), .bus_msg_o(msg),
    .bus_msg_ready_i(mr), .log_valid_o(lv), .log_addr_o(laddr),
    .log_rec_o(lrec), .log_ready_i(lr));

  btrc_partner far (.clock_i(clk), .msg_valid_i(mv), .msg_i(msg),
    .msg_ready_o(mr), .log_valid_i(lv), .log_addr_i(laddr),
    .log_i(lrec), .log_ready_o(lr), .n_msg_o(n_msg), .n_log_o(n_log),
    .last_msg_o(lmsg), .last_log_o(llog), .last_addr_o(ea));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (perf_monitor_interrupt === 1'b1) n_pmi++;

  task summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // answer taken at the edge that sees pready; only the watchdog ends a wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    `CHK(rd, v)
  endtask

  task send(input logic [1:0] p, input logic [1:0] md, input int kd);
    sent.src = {$urandom(), $urandom()};
    sent.tgt = {$urandom(), $urandom()};
    sent.kind = btrc_pkg::btrc_kind_e'(2'(kd));
    br_rec <= sent;
    current_privilege_level <= p;
    ext <= md[1];
    m64 <= md[0];
    br_valid <= 1'b1;
    // the record is taken at the edge that sees ready high
    do begin
      @(posedge clk);
    end while (br_ready !== 1'b1);
    br_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [63:0] cut(logic [63:0] v, logic [1:0] md);
    return (&md) ? v : {32'h0, v[31:0]};
  endfunction

  task pulse(input int t);
    if (t == 0) gov[0] <= 1'b1;
    if (t == 1) gov[2] <= 1'b1;
    if (t == 2) fov[1] <= 1'b1;
    if (t == 3) sthr <= 1'b1;
    @(posedge clk);
    {gov, fov, sthr} <= '0;
    repeat (5) @(posedge clk);
  endtask

  initial begin
    {psel, penable, pwrite, br_valid, ext, m64, dexc, sthr} = '0;
    paddr = '0;
    pwdata = '0;
    br_rec = '0;
    current_privilege_level = '0;
    {gov, fov, fctl} = '0;
    gsel = '0;
    gsel[2][btrc_pkg::EVTSEL_INT_BIT] = 1'b1;
    fctl[4 + btrc_pkg::FIXED_INT_BIT] = 1'b1;
    rst_n = 1'b0;
    ep = 0;
    void'($urandom(32'hfe9e));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(btrc_pkg::OFF_DEBUG_CTRL, 32'h0);
    apb(1'b0, btrc_pkg::OFF_CAPABILITY, 32'h0);
    `CHK(rd[5:0], btrc_pkg::FMT_EFF64)
    apb(1'b0, btrc_pkg::OFF_ID_ECX, 32'h0);
    `CHK(rd[4], 1'b1)
    `CHK(rd[15], 1'b1)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, btrc_pkg::OFF_DEBUG_CTRL, 32'hffffffff);
    rdchk(btrc_pkg::OFF_DEBUG_CTRL, btrc_pkg::DEBUG_CTRL_MASK);
    $display("test registers done");
    // seven records through a depth of four: pointer wraps
    apb(1'b1, btrc_pkg::OFF_DEBUG_CTRL, 32'h1);
    for (k = 0; k < 7; k++) begin
      x = 2'($urandom_range(0, 3));
      send(2'($urandom_range(0, 3)), x, k % 3 + 1);
      ep = (ep + 1) % 4;
      rdchk(btrc_pkg::OFF_NEWEST_PTR, 32'(ep));
      e = cut(sent.src, x);
      rdchk(12'h100 + 12'(8 * ep), e[31:0]);
      rdchk(12'h104 + 12'(8 * ep), e[63:32]);
      e = cut(sent.tgt, x);
      rdchk(12'h200 + 12'(8 * ep), e[31:0]);
    end
    $display("test stack done");
    dexc <= 1'b1;
    @(posedge clk);
    dexc <= 1'b0;
    @(posedge clk);
    rdchk(btrc_pkg::OFF_DEBUG_CTRL, 32'h0);
    send(2'h0, 2'h3, 1);
    rdchk(btrc_pkg::OFF_NEWEST_PTR, 32'(ep));
    $display("test debug exception done");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, btrc_pkg::OFF_DEBUG_CTRL, 32'h40 | (32'h200 << k));
      for (c = 0; c < 4; c++) begin
        m0 = n_msg;
        send(2'(c), 2'h3, 2);
        repeat (30) @(posedge clk);
        inc = (k == 0) ? int'(c != 0) : int'(c == 0);
        `CHK(n_msg - m0, inc)
        if (inc == 1) `CHK(lmsg, sent)
      end
    end
    $display("test messages done");
    apb(1'b1, btrc_pkg::OFF_LOG_BASE, 32'h1000);
    apb(1'b1, btrc_pkg::OFF_LOG_MAX, 32'h1024);
    apb(1'b1, btrc_pkg::OFF_LOG_THRESH, 32'h100c);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, btrc_pkg::OFF_LOG_INDEX, 32'h1000);
      apb(1'b1, btrc_pkg::OFF_STATUS, 32'h3);
      apb(1'b1, btrc_pkg::OFF_DEBUG_CTRL, 32'h80 | (32'h100 * k));
      m0 = n_log;
      inc = n_pmi;
      for (c = 0; c < 4; c++) begin
        send(2'h1, 2'h0, 3);
        repeat (30) @(posedge clk);
        if (k == 0 || c < 3) `CHK(ea, 32'h1000 + 32'(12 * (c % 3)))
        if (k == 0 || c < 3) `CHK(llog.src, cut(sent.src, 2'h0))
      end
      `CHK(n_log - m0, 4 - k)
      apb(1'b0, btrc_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[1:0], {k[0], 1'b1})
      `CHK(n_pmi > inc, k == 1)
    end
    $display("test memory log done");
    for (k = 0; k < 4; k++) begin
      // software restart after each freeze
      apb(1'b1, btrc_pkg::OFF_GLOBAL_EN, 32'h7f);
      apb(1'b1, btrc_pkg::OFF_DEBUG_CTRL, 32'h1801);
      inc = n_pmi;
      pulse(k);
      `CHK(n_pmi - inc, int'(k != 0))
      `CHK(cen, (k != 0) ? 7'h00 : 7'h7f)
      rdchk(btrc_pkg::OFF_DEBUG_CTRL, (k != 0) ? 32'h1800 : 32'h1801);
    end
    $display("test freeze done");
    summarize();
  end

  initial begin
    #500000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
